// ---- core/add_exec.sv ----
// addition instruction datapath with a classic wishbone register slave
//
// Notes on behaviour
// - literal add: accumulator plus literal into accumulator
// - both adds update five arithmetic flags
// - file add; destination bit picks accumulator or file
// - access bit: access bank or bank_select_reg
// - extended, access 0, f<=5Fh: indexed offset
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module add_exec
    import add_exec_pkg::*;
#(
    parameter int MEM_AW = 12                        // data memory address width
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [4:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic [31:0]              dat_o,
    output logic                     ack_o,
    // observation
    output logic                     busy_o
);
    import add_exec_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]        mem_ff [0:(1<<MEM_AW)-1];   // data memory, not cleared at reset
    phase_t            state_ff;                   // execution phase
    logic [15:0]       instr_ff;                   // instruction word under execution
    logic [7:0]        acc_ff;                     // accumulator
    logic [4:0]        status_ff;                  // arithmetic flags
    logic [3:0]        bank_ff;                    // bank_select_reg
    logic              ext_ff;                     // extended set enable
    logic [11:0]       index_base_ff;              // indexed offset base
    logic [11:0]       mem_addr_ff;                // bus pointer into memory
    logic [11:0]       eaddr_ff;                   // effective file address
    logic [7:0]        opnd_ff;                    // second operand
    logic [8:0]        sum_ff;                     // nine bit sum
    logic [4:0]        flags_ff;                   // flags of sum_ff
    logic              is_lit_ff;                  // decoded literal add
    logic              is_file_ff;                 // decoded file add
    logic              ack_ff;                     // bus acknowledge
    logic [31:0]       rdata_ff;                   // bus read data

    logic              bus_req;                    // request seen while idle
    logic              bus_wr;                     // write takes effect now
    logic [7:0]        wbyte;                      // low byte lane of write data
    logic [4:0]        nxt_flags;                  // flags computed in process phase
    logic [8:0]        nxt_sum;                    // sum computed in process phase

    // effective address of a file operand
    function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
                                              input logic ext, input logic [3:0] bank_sel,
                                              input logic [11:0] base);
        logic [11:0] r;
        r = {BANK_LOW, f};
        if (a) begin
            r = {bank_sel, f};
        end else if (ext && (f <= INDEX_LIMIT)) begin
            r = base + {4'h0, f};
        end else if (f >= ACCESS_SPLIT) begin
            r = {BANK_HIGH, f};
        end
        return r;
    endfunction

    // ****************************************************************
    // bus slave
    // ****************************************************************
    // requests are held off while an instruction runs, so software never
    // races the datapath for the accumulator or memory
    assign bus_req = cyc_i && stb_i && !ack_ff && (state_ff == ST_IDLE);
    assign bus_wr  = cyc_i && stb_i && we_i && ack_ff;
    assign wbyte   = dat_i[7:0];
    assign ack_o   = ack_ff;
    assign dat_o   = rdata_ff;
    assign busy_o  = (state_ff != ST_IDLE);

    // acknowledge one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    // read data captured with the acknowledge; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_req) begin
            unique case (adr_i)
                ADR_INSTR:      rdata_ff <= {15'h0000, busy_o, instr_ff};
                ADR_ACC:        rdata_ff <= {24'h00_0000, acc_ff};
                ADR_STATUS:     rdata_ff <= {27'h000_0000, status_ff};
                ADR_BANK_SEL:   rdata_ff <= {28'h000_0000, bank_ff};
                ADR_CTRL:       rdata_ff <= {31'h0000_0000, ext_ff};
                ADR_INDEX_BASE: rdata_ff <= {20'h0_0000, index_base_ff};
                ADR_MEM_ADDR:   rdata_ff <= {20'h0_0000, mem_addr_ff};
                ADR_MEM_DATA:   rdata_ff <= {24'h00_0000, mem_ff[mem_addr_ff]};
                default:        rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // plain configuration registers; writes land on the acknowledge edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_ff       <= BANK_RST;
            ext_ff        <= 1'b0;
            index_base_ff <= ADDR_RST;
            mem_addr_ff   <= ADDR_RST;
        end else if (bus_wr) begin
            if (adr_i == ADR_BANK_SEL && sel_i[0]) begin
                bank_ff <= dat_i[3:0];
            end
            if (adr_i == ADR_CTRL && sel_i[0]) begin
                ext_ff <= dat_i[CTRL_EXT];
            end
            if (adr_i == ADR_INDEX_BASE && sel_i[1:0] == 2'b11) begin
                index_base_ff <= dat_i[11:0];
            end
            if (adr_i == ADR_MEM_ADDR && sel_i[1:0] == 2'b11) begin
                mem_addr_ff <= dat_i[11:0];
            end
        end
    end

    // ****************************************************************
    // execution sequence
    // ****************************************************************
    // one instruction word per launch, four phases, then idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            instr_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (bus_wr && adr_i == ADR_INSTR && sel_i[1:0] == 2'b11) begin
                        instr_ff <= dat_i[15:0];
                        state_ff <= ST_DECODE;
                    end
                end
                ST_DECODE: state_ff <= ST_READ;
                ST_READ:   state_ff <= ST_PROC;
                ST_PROC:   state_ff <= ST_WRITE;
                ST_WRITE:  state_ff <= ST_IDLE;
            endcase
        end
    end

    // decode phase: classify and form the file address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            is_lit_ff  <= 1'b0;
            is_file_ff <= 1'b0;
            eaddr_ff   <= ADDR_RST;
        end else if (state_ff == ST_DECODE) begin
            is_lit_ff  <= (instr_ff[15:8] == OPC_ADD_LIT);
            is_file_ff <= (instr_ff[15:10] == OPC_ADD_FILE);
            eaddr_ff   <= file_addr(instr_ff[7:0], instr_ff[BIT_ACCESS], ext_ff,
                                    bank_ff, index_base_ff);
        end
    end

    // read phase: fetch the literal or the file register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opnd_ff <= 8'h00;
        end else if (state_ff == ST_READ) begin
            opnd_ff <= is_lit_ff ? instr_ff[7:0] : mem_ff[eaddr_ff];
        end
    end

    // process phase arithmetic; flags follow the nine bit sum and the operands
    always_comb begin
        nxt_sum              = {1'b0, acc_ff} + {1'b0, opnd_ff};
        nxt_flags            = 5'h00;
        nxt_flags[FLAG_CARRY] = nxt_sum[8];
        nxt_flags[FLAG_HALF] = ({1'b0, acc_ff[3:0]} + {1'b0, opnd_ff[3:0]}) > 5'h0F;
        nxt_flags[FLAG_ZERO] = (nxt_sum[7:0] == 8'h00);
        nxt_flags[FLAG_RANGE] = (acc_ff[7] == opnd_ff[7]) && (nxt_sum[7] != acc_ff[7]);
        nxt_flags[FLAG_NEG]  = nxt_sum[7];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sum_ff   <= 9'h000;
            flags_ff <= STATUS_RST;
        end else if (state_ff == ST_PROC) begin
            sum_ff   <= nxt_sum;
            flags_ff <= nxt_flags;
        end
    end

    // write phase: accumulator and flags; unknown opcodes change nothing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff    <= ACC_RST;
            status_ff <= STATUS_RST;
        end else if (bus_wr && adr_i == ADR_ACC && sel_i[0]) begin
            acc_ff <= wbyte;
        end else if (state_ff == ST_WRITE && (is_lit_ff || is_file_ff)) begin
            status_ff <= flags_ff;
            if (is_lit_ff || !instr_ff[BIT_DEST]) begin
                acc_ff <= sum_ff[7:0];
            end
        end
    end

    // data memory: file destination or bus byte access
    always_ff @(posedge clk_i) begin
        if (state_ff == ST_WRITE && is_file_ff && instr_ff[BIT_DEST]) begin
            mem_ff[eaddr_ff] <= sum_ff[7:0];
        end else if (bus_wr && adr_i == ADR_MEM_DATA && sel_i[0]) begin
            mem_ff[mem_addr_ff] <= wbyte;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_lit_acc;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_DECODE && instr_ff[15:8] == OPC_ADD_LIT)
        |-> ##4 acc_ff == 8'($past(acc_ff, 4) + $past(instr_ff[7:0], 4));
    endproperty
    a_lit_acc: assert property (p_lit_acc) else $error("literal add wrong");

    property p_flags;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_WRITE && (is_lit_ff || is_file_ff))
        |=> status_ff[FLAG_ZERO] == ($past(sum_ff[7:0]) == 8'h00)
            && status_ff[FLAG_CARRY] == $past(sum_ff[8])
            && status_ff[FLAG_NEG] == $past(sum_ff[7]);
    endproperty
    a_flags: assert property (p_flags) else $error("flags not from sum");

    property p_file_dest;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_WRITE && is_file_ff && instr_ff[BIT_DEST])
        |=> mem_ff[$past(eaddr_ff)] == $past(sum_ff[7:0]) && $stable(acc_ff);
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file dest wrong");

    property p_bank;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_READ && is_file_ff && instr_ff[BIT_ACCESS])
        |-> eaddr_ff == {bank_ff, instr_ff[7:0]};
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");

    property p_indexed;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_READ && is_file_ff && !instr_ff[BIT_ACCESS] && ext_ff
         && instr_ff[7:0] <= INDEX_LIMIT)
        |-> eaddr_ff == 12'(index_base_ff + {4'h0, instr_ff[7:0]});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_phases;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_DECODE) |=> state_ff == ST_READ ##1 state_ff == ST_PROC
            ##1 state_ff == ST_WRITE ##1 state_ff == ST_IDLE;
    endproperty
    a_phases: assert property (p_phases) else $error("phase order wrong");

    c_lit:   cover property (@(posedge clk_i) state_ff == ST_WRITE && is_lit_ff);
    c_to_w:  cover property (@(posedge clk_i) state_ff == ST_WRITE && is_file_ff
                             && !instr_ff[BIT_DEST]);
    c_to_f:  cover property (@(posedge clk_i) state_ff == ST_WRITE && is_file_ff
                             && instr_ff[BIT_DEST]);
    c_index: cover property (@(posedge clk_i) state_ff == ST_READ && is_file_ff && ext_ff
                             && !instr_ff[BIT_ACCESS] && instr_ff[7:0] <= INDEX_LIMIT);

endmodule

`default_nettype wire

// ---- core/add_exec_pkg.sv ----
// constants shared by the addition execution datapath and its bench
package add_exec_pkg;

    // ****************************************************************
    // bus register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [4:0] ADR_INSTR      = 5'h00;  // write launches, read returns the word with busy always 0
    localparam logic [4:0] ADR_ACC        = 5'h04;  // accumulator
    localparam logic [4:0] ADR_STATUS     = 5'h08;  // arithmetic flags, read only
    localparam logic [4:0] ADR_BANK_SEL   = 5'h0C;  // bank_select_reg
    localparam logic [4:0] ADR_CTRL       = 5'h10;  // extended set enable
    localparam logic [4:0] ADR_INDEX_BASE = 5'h14;  // base for indexed literal offset
    localparam logic [4:0] ADR_MEM_ADDR   = 5'h18;  // pointer into data memory
    localparam logic [4:0] ADR_MEM_DATA   = 5'h1C;  // byte at pointer

    // ****************************************************************
    // status field positions and reset values
    // ****************************************************************
    localparam int FLAG_CARRY = 0;  // arith_output_spill
    localparam int FLAG_HALF  = 1;  // low_nibble_spill
    localparam int FLAG_ZERO  = 2;  // result_all_clear
    localparam int FLAG_RANGE = 3;  // signed_range_fault
    localparam int FLAG_NEG   = 4;  // top_bit_of_result
    localparam int CTRL_EXT   = 0;  // extended instruction set enable
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [4:0]  STATUS_RST = 5'h00;
    localparam logic [3:0]  BANK_RST   = 4'h0;
    localparam logic [11:0] ADDR_RST   = 12'h000;

    // ****************************************************************
    // instruction encodings and addressing
    // ****************************************************************
    localparam logic [7:0] OPC_ADD_LIT  = 8'h0F;    // upper byte of add_literal_op
    localparam logic [5:0] OPC_ADD_FILE = 6'h09;    // upper six bits of add_to_file_op
    localparam int         BIT_DEST     = 9;        // destination select
    localparam int         BIT_ACCESS   = 8;        // access select
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;    // first access address in top bank
    localparam logic [7:0] INDEX_LIMIT  = 8'h5F;    // highest indexed offset
    localparam logic [3:0] BANK_LOW     = 4'h0;     // access bank lower half
    localparam logic [3:0] BANK_HIGH    = 4'hF;     // access bank upper half

    // execution phases of one instruction cycle
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_READ,
        ST_PROC,
        ST_WRITE
    } phase_t;

endpackage

// ---- tb/tb_add_exec.sv ----
// self-checking bench for the addition execution datapath
`timescale 1ns/1ps
`default_nettype none

module tb_add_exec;
    import add_exec_pkg::*;

    // ****************************************************************
    // stimulus and observation signals
    // ****************************************************************
    logic        clk_i;          // 25 MHz core clock
    logic        rst_i;          // synchronous reset, active high
    logic        cyc_i;          // bus cycle
    logic        stb_i;          // bus strobe
    logic        we_i;           // write when high
    logic [4:0]  adr_i;          // byte address
    logic [3:0]  sel_i;          // lane enables
    logic [31:0] dat_i;          // write data
    logic [31:0] dat_o;          // read data
    logic        ack_o;          // acknowledge pulse
    logic        busy_o;         // instruction in flight
    int          n_mismatch;     // failed comparisons
    int          checks;         // all comparisons
    logic [31:0] rdat;           // last read value

    add_exec add_exec_i (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cyc_i  (cyc_i),
        .stb_i  (stb_i),
        .we_i   (we_i),
        .adr_i  (adr_i),
        .sel_i  (sel_i),
        .dat_i  (dat_i),
        .dat_o  (dat_o),
        .ack_o  (ack_o),
        .busy_o (busy_o)
    );

    // free-running clock, 40 ns period
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ****************************************************************
    // bus and comparison tasks
    // ****************************************************************
    // compare and count; only a mismatch prints
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // read and compare with an expected word
    task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(name, rdat, exp);
    endtask

    // launch one instruction and watch its four phases
    task automatic exec(input logic [15:0] word);
        wr(ADR_INSTR, {16'h0000, word});
        #1 check("busy_launch", {31'h0, busy_o}, 32'h1);
        repeat (3) @(posedge clk_i);
        #1 check("busy_write", {31'h0, busy_o}, 32'h1);
        @(posedge clk_i);
        #1 check("busy_done", {31'h0, busy_o}, 32'h0);
    endtask

    // reference flags of an 8-bit add, worked out independently
    function automatic logic [31:0] flags(input logic [7:0] x, input logic [7:0] y);
        logic [8:0]  s;
        logic [31:0] f;
        s = {1'b0, x} + {1'b0, y};
        f = 32'h0000_0000;
        f[FLAG_CARRY] = s[8];
        f[FLAG_HALF]  = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F;
        f[FLAG_ZERO]  = (s[7:0] == 8'h00);
        f[FLAG_RANGE] = (x[7] == y[7]) && (s[7] != x[7]);
        f[FLAG_NEG]   = s[7];
        return f;
    endfunction

    // literal add case: accumulator and flags afterwards
    task automatic lit_case(input logic [7:0] w, input logic [7:0] k);
        logic [7:0] s;
        s = w + k;
        wr(ADR_ACC, {24'h0, w});
        exec({OPC_ADD_LIT, k});
        rd_chk("acc_lit", ADR_ACC, {24'h0, s});
        rd_chk("status_lit", ADR_STATUS, flags(w, k));
    endtask

    // file add case: addr is where the operand must be found
    task automatic file_case(input logic [3:0] bank, input logic ext, input logic [11:0] addr,
                             input logic [7:0] f, input logic a, input logic d,
                             input logic [7:0] w, input logic [7:0] m);
        logic [7:0] s;
        s = w + m;
        wr(ADR_BANK_SEL, {28'h0, bank});
        wr(ADR_CTRL, {31'h0, ext});
        wr(ADR_MEM_ADDR, {20'h0, addr});
        wr(ADR_MEM_DATA, {24'h0, m});
        wr(ADR_ACC, {24'h0, w});
        exec({OPC_ADD_FILE, d, a, f});
        rd_chk("acc_file", ADR_ACC, {24'h0, (d ? w : s)});
        rd_chk("mem_file", ADR_MEM_DATA, {24'h0, (d ? s : m)});
        rd_chk("status_file", ADR_STATUS, flags(w, m));
    endtask

    // ****************************************************************
    // verdict and watchdog
    // ****************************************************************
    task automatic finish_test;
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        finish_test;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        n_mismatch = 0;
        checks     = 0;
        rst_i      = 1'b1;
        cyc_i      = 1'b0;
        stb_i      = 1'b0;
        we_i       = 1'b0;
        adr_i      = 5'h00;
        sel_i      = 4'h0;
        dat_i      = 32'h0000_0000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, and an unaligned place that reads as zero
        rd_chk("acc_rst", ADR_ACC, {24'h0, ACC_RST});
        rd_chk("status_rst", ADR_STATUS, {27'h0, STATUS_RST});
        rd_chk("bank_rst", ADR_BANK_SEL, {28'h0, BANK_RST});
        rd_chk("addr_rst", ADR_MEM_ADDR, {20'h0, ADDR_RST});
        rd_chk("ext_rst", ADR_CTRL, 32'h0000_0000);
        rd_chk("unmapped", 5'h02, 32'h0000_0000);
        // plain, overflow, carry-to-zero and double-negative sums
        lit_case(8'h10, 8'h15);
        lit_case(8'h7F, 8'h01);
        lit_case(8'hFF, 8'h01);
        lit_case(8'h80, 8'h80);
        // a read-only status must ignore a bus write
        wr(ADR_STATUS, 32'h0000_001F);
        rd_chk("status_ro", ADR_STATUS, flags(8'h80, 8'h80));
        // an unknown opcode runs its phases and changes nothing
        exec(16'h0B05);
        rd_chk("acc_nop", ADR_ACC, 32'h0000_0000);
        rd_chk("status_nop", ADR_STATUS, flags(8'h80, 8'h80));
        rd_chk("instr_rb", ADR_INSTR, 32'h0000_0B05);
        // a read issued mid-instruction is held off and sees the result
        wr(ADR_ACC, 32'h0000_0010);
        wr(ADR_INSTR, {16'h0000, OPC_ADD_LIT, 8'h15});
        rd_chk("acc_stall", ADR_ACC, 32'h0000_0025);
        // indexed base used by the extended cases
        wr(ADR_INDEX_BASE, 32'h0000_0200);
        rd_chk("base_rb", ADR_INDEX_BASE, 32'h0000_0200);
        file_case(4'h3, 1'b0, 12'h3C2, 8'hC2, 1'b1, 1'b0, 8'h17, 8'hC2);
        file_case(4'h3, 1'b0, 12'hF70, 8'h70, 1'b0, 1'b1, 8'hB0, 8'h50);
        file_case(4'h5, 1'b0, 12'h020, 8'h20, 1'b0, 1'b1, 8'h22, 8'h11);
        file_case(4'h0, 1'b1, 12'h25F, 8'h5F, 1'b0, 1'b1, 8'h08, 8'h08);
        file_case(4'h0, 1'b1, 12'hF60, 8'h60, 1'b0, 1'b0, 8'h7F, 8'h7F);
        file_case(4'h7, 1'b1, 12'h720, 8'h20, 1'b1, 1'b1, 8'h01, 8'h02);
        finish_test;
    end

endmodule

`default_nettype wire
